// file: hdl/spd_eeprom_i2c_protect_front.sv
`timescale 1ns/100ps
`include "spd_front_defines.svh"
module spd_eeprom_i2c_protect_front
	import spd_front_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic scl_clk_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	input wire logic [2:0] chip_sel_pin_in,
	input wire logic elevated_select_voltage_in,
	input wire logic write_guard_n_in,
	input wire logic por_active_in,
	input wire logic lower_lock_in,
	input wire logic perm_lock_in,
	input wire logic write_done_in,
	output cmd_event_type session_out,
	output cmd_event_type launch_out,
	output logic lower_wr_ok_out,
	output logic array_wr_ok_out,
	output logic busy_out
);
	typedef enum logic [2:0] {ST_IDLE, ST_SEL, ST_WADDR, ST_WDATA, ST_WAIT, ST_BUSY} state_type;

	// Link side: the bit is caught on the rising serial clock and flagged by a toggle.
	logic link_bit_ff, link_tog_ff, nxt_link_tog;
	always_comb
	begin
		nxt_link_tog = ~link_tog_ff;
	end
	always_ff @(posedge scl_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			link_bit_ff <= 1'b0;
			link_tog_ff <= 1'b0;
		end
		else
		begin
			link_bit_ff <= sda_in;
			link_tog_ff <= nxt_link_tog;
		end
	end

	// Pins and the toggle pass two flip-flops; a third copy serves edge detection.
	pin_set_type pin_raw, pin_q1_ff, pin_q2_ff, pin_q3_ff;
	logic tog_q1_ff, tog_q2_ff, tog_q3_ff;
	always_comb
	begin
		pin_raw.por = por_active_in;
		pin_raw.guard = write_guard_n_in;
		pin_raw.hv = elevated_select_voltage_in;
		pin_raw.cs = chip_sel_pin_in;
		pin_raw.sda = sda_in;
		pin_raw.scl = scl_clk_in;
	end
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			pin_q1_ff <= '0;
			pin_q2_ff <= '0;
			pin_q3_ff <= '0;
			tog_q1_ff <= 1'b0;
			tog_q2_ff <= 1'b0;
			tog_q3_ff <= 1'b0;
		end
		else
		begin
			pin_q1_ff <= pin_raw;
			pin_q2_ff <= pin_q1_ff;
			pin_q3_ff <= pin_q2_ff;
			tog_q1_ff <= link_tog_ff;
			tog_q2_ff <= tog_q1_ff;
			tog_q3_ff <= tog_q2_ff;
		end
	end

	logic start_evt, stop_evt, scl_fall, bit_evt;
	always_comb
	begin
		start_evt = pin_q2_ff.scl && pin_q3_ff.scl && pin_q3_ff.sda && !pin_q2_ff.sda;
		stop_evt = pin_q2_ff.scl && pin_q3_ff.scl && !pin_q3_ff.sda && pin_q2_ff.sda;
		scl_fall = pin_q3_ff.scl && !pin_q2_ff.scl;
		bit_evt = tog_q2_ff ^ tog_q3_ff;
	end

	function automatic cmd_kind_type decode_sel(input logic [7:0] sel, input logic [2:0] cs,
		input logic hv, input logic perm);
		decode_sel = CMD_NONE;
		if (sel[7:4] == `SEL_ARRAY_ID && sel[3:1] == cs)
			decode_sel = CMD_ARRAY;
		else if (sel[7:4] == `SEL_PROT_ID && !perm)
		begin
			if (hv && sel[3:1] == `SEL_SET_CODE && cs[2:1] == `PIN_SET_LVL)
				decode_sel = CMD_SET;
			else if (hv && sel[3:1] == `SEL_CLR_CODE && cs[2:1] == `PIN_CLR_LVL)
				decode_sel = CMD_CLR;
			else if (sel[3:1] == cs)
				decode_sel = CMD_PERM;
		end
	endfunction : decode_sel

	state_type state_ff, nxt_state;
	logic [3:0] cnt_ff, nxt_cnt;
	logic [7:0] shift_ff, nxt_shift;
	logic ack_pend_ff, nxt_ack_pend, data_ok_ff, nxt_data_ok;
	logic oe_ff, nxt_oe, sda_ff;
	cmd_kind_type kind_ff, nxt_kind;
	cmd_event_type session_ff, nxt_session, launch_ff, nxt_launch;
	logic lower_ok_ff, nxt_lower_ok, array_ok_ff, nxt_array_ok, busy_ff, nxt_busy;
	logic [7:0] byte_in;
	cmd_kind_type dec;

	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_shift = shift_ff;
		nxt_ack_pend = ack_pend_ff;
		nxt_data_ok = data_ok_ff;
		nxt_oe = oe_ff;
		nxt_kind = kind_ff;
		nxt_session = '0;
		nxt_launch = '0;
		byte_in = {shift_ff[6:0], link_bit_ff};
		dec = decode_sel(byte_in, pin_q2_ff.cs, pin_q2_ff.hv, perm_lock_in);
		nxt_array_ok = !pin_q2_ff.guard;
		nxt_lower_ok = !pin_q2_ff.guard && !lower_lock_in && !perm_lock_in;
		// Acknowledge drive spans from one falling clock to the next.
		if (scl_fall)
		begin
			nxt_oe = ack_pend_ff && cnt_ff == `BIT_ACK && !oe_ff;
			nxt_ack_pend = 1'b0;
		end
		if (pin_q2_ff.por)
		begin
			nxt_state = ST_IDLE;
			nxt_cnt = `BIT_ZERO;
			nxt_oe = 1'b0;
			nxt_ack_pend = 1'b0;
			nxt_data_ok = 1'b0;
		end
		else if (state_ff == ST_BUSY)
		begin
			if (write_done_in)
				nxt_state = ST_IDLE;
		end
		else if (start_evt)
		begin
			nxt_state = ST_SEL;
			nxt_cnt = `BIT_ZERO;
			nxt_oe = 1'b0;
			nxt_ack_pend = 1'b0;
			nxt_data_ok = 1'b0;
		end
		else if (stop_evt)
		begin
			nxt_oe = 1'b0;
			nxt_ack_pend = 1'b0;
			nxt_data_ok = 1'b0;
			if (state_ff == ST_WDATA && data_ok_ff && cnt_ff == `BIT_TENTH)
			begin
				nxt_state = ST_BUSY;
				nxt_launch = '{valid: 1'b1, rd: 1'b0, kind: kind_ff};
			end
			else
				nxt_state = ST_IDLE;
		end
		else if (bit_evt && state_ff != ST_IDLE)
		begin
			if (cnt_ff == `BIT_ACK)
				nxt_cnt = `BIT_ZERO;
			else
			begin
				nxt_shift = byte_in;
				nxt_cnt = cnt_ff + 4'h1;
				// The clock rise that leads into a stop sits in the tenth slot and keeps the grant.
				nxt_data_ok = data_ok_ff && cnt_ff == `BIT_ZERO;
			end
			if (cnt_ff == `BIT_LAST)
			begin
				unique case (state_ff)
					ST_SEL:
					begin
						nxt_kind = dec;
						if (dec == CMD_NONE)
							nxt_state = ST_IDLE;
						else
						begin
							nxt_session = '{valid: 1'b1, rd: byte_in[0], kind: dec};
							nxt_state = byte_in[0] ? ST_WAIT : ST_WADDR;
							if (!byte_in[0] || dec == CMD_ARRAY)
								nxt_ack_pend = 1'b1;
							else if (dec == CMD_PERM)
								nxt_ack_pend = !perm_lock_in;
							else
								nxt_ack_pend = !lower_lock_in;
						end
					end
					ST_WADDR:
					begin
						nxt_ack_pend = 1'b1;
						nxt_state = ST_WDATA;
					end
					ST_WDATA:
					begin
						nxt_ack_pend = !pin_q2_ff.guard;
						nxt_data_ok = !pin_q2_ff.guard;
					end
					ST_IDLE, ST_WAIT, ST_BUSY:
					begin
					end
				endcase
			end
		end
		nxt_busy = (nxt_state == ST_BUSY);
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			state_ff <= ST_IDLE;
			cnt_ff <= `BIT_ZERO;
			shift_ff <= 8'h00;
			ack_pend_ff <= 1'b0;
			data_ok_ff <= 1'b0;
			oe_ff <= 1'b0;
			sda_ff <= 1'b0;
			kind_ff <= CMD_NONE;
			session_ff <= '0;
			launch_ff <= '0;
			lower_ok_ff <= 1'b0;
			array_ok_ff <= 1'b0;
			busy_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			shift_ff <= nxt_shift;
			ack_pend_ff <= nxt_ack_pend;
			data_ok_ff <= nxt_data_ok;
			oe_ff <= nxt_oe;
			sda_ff <= 1'b0;
			kind_ff <= nxt_kind;
			session_ff <= nxt_session;
			launch_ff <= nxt_launch;
			lower_ok_ff <= nxt_lower_ok;
			array_ok_ff <= nxt_array_ok;
			busy_ff <= nxt_busy;
		end
	end

	// The pin is only ever pulled low; the bus is never driven high.
	assign sda_out = sda_ff;
	assign sda_oe_out = oe_ff;
	assign session_out = session_ff;
	assign launch_out = launch_ff;
	assign lower_wr_ok_out = lower_ok_ff;
	assign array_wr_ok_out = array_ok_ff;
	assign busy_out = busy_ff;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	AST_GUARD_NACK: assert property (
		state_ff == ST_WDATA && bit_evt && cnt_ff == `BIT_LAST && pin_q2_ff.guard
		&& !pin_q2_ff.por && !start_evt && !stop_evt |=> !ack_pend_ff && !data_ok_ff)
		else $error("Write data acknowledged while guarded.");
	AST_LOWER_OK: assert property (
		lower_wr_ok_out |-> !$past(lower_lock_in) && !$past(perm_lock_in) && !$past(pin_q2_ff.guard))
		else $error("Lower half writable while locked.");
	AST_POR_QUIET: assert property (
		pin_q2_ff.por |=> state_ff == ST_IDLE && !sda_oe_out && !ack_pend_ff)
		else $error("Bus response during power-on reset.");
	AST_POR_IDLE: assert property (
		pin_q2_ff.por ##1 !pin_q2_ff.por |-> state_ff == ST_IDLE && cnt_ff == `BIT_ZERO)
		else $error("Not idle after power-on reset release.");
	AST_STOP_IDLE: assert property (
		stop_evt && !pin_q2_ff.por && state_ff != ST_BUSY && !data_ok_ff |=> state_ff == ST_IDLE)
		else $error("Stop did not end communication.");
	AST_LAUNCH_STOP: assert property (
		launch_out.valid |-> $past(stop_evt) && $past(data_ok_ff) && busy_out)
		else $error("Write cycle launched without a stop after data.");
	AST_MISMATCH: assert property (
		state_ff == ST_SEL && bit_evt && cnt_ff == `BIT_LAST && dec == CMD_NONE
		&& !pin_q2_ff.por && !start_evt && !stop_evt |=> state_ff == ST_IDLE && !ack_pend_ff)
		else $error("Mismatched select not released.");
	AST_ACK_WINDOW: assert property (
		$rose(sda_oe_out) |-> $past(scl_fall) && $past(ack_pend_ff) && !pin_q2_ff.scl)
		else $error("Acknowledge not driven after falling clock.");
	AST_BUSY_DEAF: assert property (
		state_ff == ST_BUSY && !write_done_in && !pin_q2_ff.por |=> state_ff == ST_BUSY)
		else $error("Bus activity seen during write cycle.");
endmodule : spd_eeprom_i2c_protect_front

// file: pkg/spd_front_defines.svh
`ifndef SPD_FRONT_DEFINES_SVH
`define SPD_FRONT_DEFINES_SVH
// Device type identifiers of the select byte.
`define SEL_ARRAY_ID 4'hA
`define SEL_PROT_ID 4'h6
// Select bits b3..b1 and pin 2..1 levels of the set and clear lock commands.
`define SEL_SET_CODE 3'h1
`define SEL_CLR_CODE 3'h3
`define PIN_SET_LVL 2'h0
`define PIN_CLR_LVL 2'h1
// Bit counter values: last data bit, acknowledge slot, start of a byte and the tenth slot.
`define BIT_LAST 4'h7
`define BIT_ACK 4'h8
`define BIT_ZERO 4'h0
`define BIT_TENTH 4'h1
`endif

// file: pkg/spd_front_pkg.sv
package spd_front_pkg;
	typedef enum logic [2:0] {CMD_NONE, CMD_ARRAY, CMD_SET, CMD_CLR, CMD_PERM} cmd_kind_type;
	typedef struct packed {
		logic valid;
		logic rd;
		cmd_kind_type kind;
	} cmd_event_type;
	typedef struct packed {
		logic por;
		logic guard;
		logic hv;
		logic [2:0] cs;
		logic sda;
		logic scl;
	} pin_set_type;
endpackage : spd_front_pkg

// file: verification/twi_master_model.sv
`timescale 1ns/100ps
module twi_master_model (
	output logic scl_out,
	output logic sda_drv_out,
	input wire logic sda_in
);
	localparam realtime Q = 31.25;
	initial
	begin
		scl_out = 1'b1;
		sda_drv_out = 1'b1;
	end
	// Only this model moves the serial clock, and it rests high between frames.
	task start_c;
		sda_drv_out = 1'b1;
		scl_out = 1'b1;
		#(2*Q) sda_drv_out = 1'b0;
		#(2*Q) scl_out = 1'b0;
	endtask : start_c
	task stop_c;
		#Q sda_drv_out = 1'b0;
		#Q scl_out = 1'b1;
		#(2*Q) sda_drv_out = 1'b1;
		#(2*Q);
	endtask : stop_c
	task put_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--)
		begin
			#Q sda_drv_out = b[i];
			#Q scl_out = 1'b1;
			#(2*Q) scl_out = 1'b0;
		end
		#Q sda_drv_out = 1'b1;
		#Q scl_out = 1'b1;
		#Q ack = ~sda_in;
		#Q scl_out = 1'b0;
	endtask : put_byte
endmodule : twi_master_model

// file: verification/spd_eeprom_i2c_protect_front_tb.sv
`timescale 1ns/100ps
module spd_eeprom_i2c_protect_front_tb;
	import spd_front_pkg::*;
	logic clk_in = 1'b0;
	logic rst_in, scl, sda_drv, sda_out, sda_oe_out, hv, guard, por, lo_lk, pm_lk, wdone;
	logic lower_ok, array_ok, busy;
	logic [2:0] pins;
	cmd_event_type session_out, launch_out, last_l, last_s;
	int mismatches, n_checks, n_l, n_s;
	wire logic sda_w = sda_drv & ~(sda_oe_out & ~sda_out);
	always #2.5 clk_in = ~clk_in;
	always @(posedge clk_in)
	begin
		if (launch_out.valid === 1'b1)
		begin
			n_l++;
			last_l = launch_out;
		end
		if (session_out.valid === 1'b1)
		begin
			n_s++;
			last_s = session_out;
		end
	end
	spd_eeprom_i2c_protect_front spd_eeprom_i2c_protect_front_i (.clk_in(clk_in),
		.rst_in(rst_in), .scl_clk_in(scl), .sda_in(sda_w), .sda_out(sda_out),
		.sda_oe_out(sda_oe_out), .chip_sel_pin_in(pins), .elevated_select_voltage_in(hv),
		.write_guard_n_in(guard), .por_active_in(por), .lower_lock_in(lo_lk),
		.perm_lock_in(pm_lk), .write_done_in(wdone), .session_out(session_out),
		.launch_out(launch_out), .lower_wr_ok_out(lower_ok), .array_wr_ok_out(array_ok),
		.busy_out(busy));
	twi_master_model twi_master_model_i (.scl_out(scl), .sda_drv_out(sda_drv), .sda_in(sda_w));
	task wrap_up;
		if (mismatches == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up
	task chk(input logic c, input string m);
		n_checks++;
		if (c !== 1'b1)
		begin
			mismatches++;
			$display("BAD %0t %s", $time, m);
		end
	endtask : chk
	task cycles(input int n);
		repeat (n) @(negedge clk_in);
	endtask : cycles
	task cmd(input logic [7:0] sel, input int nb, output logic [2:0] a);
		logic k;
		a = 3'h0;
		twi_master_model_i.start_c();
		twi_master_model_i.put_byte(sel, k);
		a[0] = k;
		for (int i = 1; i <= nb; i++)
		begin
			twi_master_model_i.put_byte(8'h5A, k);
			a[i] = k;
		end
		twi_master_model_i.stop_c();
		cycles(6);
	endtask : cmd
	task expect_launch(input cmd_kind_type kd, input int n0);
		logic [2:0] a;
		int s0;
		chk(n_l == n0 + 1 && last_l.kind === kd && last_l.rd === 1'b0, "launch kind");
		chk(busy === 1'b1, "busy not set");
		s0 = n_s;
		cmd({4'hA, pins, 1'b1}, 0, a);
		chk(a[0] === 1'b0 && n_s == s0, "ack while busy");
		wdone = 1'b1;
		cycles(1);
		wdone = 1'b0;
		cycles(3);
		chk(busy === 1'b0, "busy stuck");
		cmd({4'hA, pins, 1'b1}, 0, a);
		chk(a[0] === 1'b1, "no ack after write cycle");
	endtask : expect_launch
	task sc_array;
		logic [2:0] a;
		int n0, s0;
		n0 = n_l;
		cmd(8'hAA, 2, a);
		chk(a === 3'h7 && array_ok === 1'b1, "array write");
		chk(last_s.kind === CMD_ARRAY && last_s.rd === 1'b0, "array session");
		expect_launch(CMD_ARRAY, n0);
		s0 = n_s;
		cmd(8'hA4, 2, a);
		chk(a === 3'h0 && n_l == n0 + 1 && n_s == s0, "mismatch");
	endtask : sc_array
	task sc_guard;
		logic [2:0] a;
		int n0;
		n0 = n_l;
		guard = 1'b1;
		cycles(6);
		chk(array_ok === 1'b0 && lower_ok === 1'b0, "guard ok flags");
		cmd(8'hAA, 2, a);
		chk(a === 3'h3 && n_l == n0, "guarded write");
		guard = 1'b0;
	endtask : sc_guard
	task sc_locks;
		logic [2:0] a;
		int n0;
		hv = 1'b1;
		pins = 3'h1;
		n0 = n_l;
		cmd(8'h62, 2, a);
		chk(a === 3'h7, "set ack");
		expect_launch(CMD_SET, n0);
		pins = 3'h3;
		n0 = n_l;
		cmd(8'h66, 2, a);
		chk(a === 3'h7, "clear ack");
		expect_launch(CMD_CLR, n0);
		cmd(8'h67, 0, a);
		chk(a[0] === 1'b1 && last_s.kind === CMD_CLR && last_s.rd === 1'b1, "clear read");
		pins = 3'h1;
		lo_lk = 1'b1;
		cmd(8'h63, 0, a);
		chk(a[0] === 1'b0 && lower_ok === 1'b0, "lock read");
		lo_lk = 1'b0;
		hv = 1'b0;
		pins = 3'h5;
		cycles(2);
		chk(lower_ok === 1'b1, "lower ok");
	endtask : sc_locks
	task sc_perm;
		logic [2:0] a;
		int n0;
		n0 = n_l;
		cmd(8'h6A, 2, a);
		chk(a === 3'h7, "perm ack");
		expect_launch(CMD_PERM, n0);
		cmd(8'h6B, 0, a);
		chk(a[0] === 1'b1 && last_s.kind === CMD_PERM, "perm read");
		pm_lk = 1'b1;
		n0 = n_l;
		cmd(8'h6A, 2, a);
		chk(a === 3'h0 && n_l == n0 && lower_ok === 1'b0, "perm locked");
		cmd(8'h6B, 0, a);
		chk(a[0] === 1'b0, "perm read locked");
		pm_lk = 1'b0;
	endtask : sc_perm
	task sc_por;
		logic [2:0] a;
		int s0;
		por = 1'b1;
		cycles(4);
		s0 = n_s;
		cmd(8'hAA, 0, a);
		chk(a[0] === 1'b0 && n_s == s0, "por ack");
		por = 1'b0;
		cycles(4);
		cmd(8'hAB, 0, a);
		chk(a[0] === 1'b1, "read after por");
		chk(last_s.kind === CMD_ARRAY && last_s.rd === 1'b1, "read session");
	endtask : sc_por
	initial
	begin
		rst_in = 1'b1;
		{hv, guard, por, lo_lk, pm_lk, wdone} = 6'h00;
		pins = 3'h5;
		repeat (6) @(posedge clk_in);
		cycles(1);
		rst_in = 1'b0;
		cycles(4);
		sc_array();
		sc_guard();
		sc_locks();
		sc_perm();
		sc_por();
		wrap_up();
	end
	initial
	begin
		#400us;
		mismatches++;
		wrap_up();
	end
endmodule : spd_eeprom_i2c_protect_front_tb
